// *** dv/sepc_checker.sv ***
// pin-level assertions for the serial eeprom program control block
`timescale 1ns/1ps
`default_nettype none
module sepc_checker #(
  parameter int PROG_CYCLES = 300  // self-timed length in clk cycles
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic power_good,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic word_width_select,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en,
  input wire logic program_busy
);
  import sepc_pkg::*;
  localparam int LEN_MAX = PROG_CYCLES + 4;  // slack for the pin flops
  logic [19:0] busy_len;       // cycles the running cycle has lasted
  logic [19:0] next_busy_len;  // counter input
  // length counter, cleared while idle
  always_comb next_busy_len = program_busy ? busy_len + 20'h1 : 20'h0;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) busy_len <= 20'h0;
    else busy_len <= next_busy_len;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////
  AST_RST_QUIET: assert property (!$past(resetn) |-> !program_busy && !serial_data_out_en)
    else $error("active right after reset");
  AST_PG_HOLD: assert property (!power_good [*6] |-> !program_busy && !serial_data_out_en)
    else $error("active while power is low");
  AST_LAUNCH_DESEL: assert property ($rose(program_busy) |-> !chip_select && !$past(chip_select, 2))
    else $error("cycle started while selected");
  AST_BUSY_HOLD: assert property ($rose(program_busy) |=> program_busy [*8])
    else $error("cycle ended at once");
  AST_CYCLE_LEN: assert property (
    $fell(program_busy) && power_good |-> busy_len >= SWEEP_CYC && busy_len <= LEN_MAX)
    else $error("cycle length out of range");
  AST_STATUS_LOW: assert property (serial_data_out_en && program_busy |-> !serial_data_out)
    else $error("ready shown while busy");
  AST_STATUS_HIGH: assert property ($fell(program_busy) && chip_select && serial_data_out_en
    |-> ##[0:2] serial_data_out)
    else $error("ready not shown");
  AST_STATUS_SHOWN: assert property ($rose(chip_select) && program_busy ##1 chip_select [*5]
    |-> serial_data_out_en)
    else $error("status not driven");
  AST_OE_RELEASE: assert property ($fell(chip_select) |-> ##[1:4] !serial_data_out_en)
    else $error("data out still driven");
  AST_READ_DUMMY: assert property ($rose(serial_data_out_en) && !program_busy |-> !serial_data_out)
    else $error("read lacks leading zero");
endmodule : sepc_checker
////////////////////////////////
bind sepc_top sepc_checker #(.PROG_CYCLES(PROG_CYCLES)) u_sepc_checker (.clk(clk), .resetn(resetn),
  .power_good(power_good), .chip_select(chip_select), .serial_clock(serial_clock), .serial_data_in(serial_data_in),
  .word_width_select(word_width_select), .serial_data_out(serial_data_out),
  .serial_data_out_en(serial_data_out_en), .program_busy(program_busy));
`default_nettype wire

// *** dv/sepc_host.sv ***
// host model driving the three-wire link: frames, reads and status polls
`timescale 1ns/1ps
`default_nettype none
module sepc_host (
  input  wire logic clk,
  input  wire logic dout,  // resolved data-out pin
  output var  logic cs,
  output var  logic sk,
  output var  logic din
);
  // idle link: deselected, serial clock parked low
  initial begin
    cs = 1'b0;
    sk = 1'b0;
    din = 1'b0;
  end
  // n bits msb first, 400 ns per serial clock
  task automatic send(input logic [26:0] bits, input int n);
    cs <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      din <= bits[i];
      repeat (4) @(posedge clk);
      sk <= 1'b1;
      repeat (4) @(posedge clk);
      sk <= 1'b0;
    end
    din <= ~bits[0];  // a released line must not keep its last value
  endtask : send
  // deselect; low time covers deselect_min_time
  task automatic close();
    cs <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : close
  // clock out a read, sampling each bit just before the next rise
  task automatic fetch(input int n, output logic [16:0] q);
    q = 17'h0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      q[i] = dout;
      sk <= 1'b1;
      repeat (4) @(posedge clk);
      sk <= 1'b0;
    end
  endtask : fetch
  // watch status; nothing new goes out before ready
  task automatic await_ready(output logic first, output int waited);
    cs <= 1'b1;
    repeat (6) @(posedge clk);
    first = dout;
    waited = 0;
    while (dout !== 1'b1 && waited < 2000) begin
      @(posedge clk);
      waited++;
    end
    cs <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : await_ready
endmodule : sepc_host
`default_nettype wire

// *** dv/sepc_top_tb.sv ***
// self-checking bench for the serial eeprom program control block
`timescale 1ns/1ps
`default_nettype none
module sepc_top_tb;
  import sepc_pkg::*;
  localparam int PROG = 300;  // short cycle, still above the 256-byte sweep
  typedef struct packed {
    logic [26:0] bits;  // frame, msb first, right aligned
    logic [4:0]  n;     // serial clocks sent
    logic        rd;    // read a word back
    logic        busy;  // a cycle should start
    logic [15:0] data;  // word expected on read
  } sepc_row_t;
  logic      clk, resetn, power_good, word_width_select;
  wire logic chip_select, serial_clock, serial_data_in;
  wire logic serial_data_out, serial_data_out_en, program_busy;
  wire logic dout_pin;  // resolved data-out wire
  int        n_errors = 0;
  int        checks = 0;
  logic      sel_first;  // status level seen on a late reselect
  int        sel_wait;   // cycles waited on that reselect
  sepc_row_t rows [15];
  assign dout_pin = serial_data_out_en ? serial_data_out : 1'bz;
  sepc_top #(.PROG_CYCLES(PROG)) u_sepc_top (.clk(clk), .resetn(resetn), .power_good(power_good),
    .chip_select(chip_select), .serial_clock(serial_clock), .serial_data_in(serial_data_in),
    .word_width_select(word_width_select), .serial_data_out(serial_data_out),
    .serial_data_out_en(serial_data_out_en), .program_busy(program_busy));
  sepc_host u_sepc_host (.clk(clk), .dout(dout_pin), .cs(chip_select), .sk(serial_clock), .din(serial_data_in));
  ////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // counts, verdict, stop
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // frame, optional read-back, then launch and status checks
  task automatic run(input sepc_row_t r);
    logic [16:0] q;
    logic        first;
    int          w;
    u_sepc_host.send(r.bits, int'(r.n));
    if (r.rd) begin
      u_sepc_host.fetch(word_width_select ? 17 : 9, q);
      check("read", {1'b0, r.data}, q);
    end
    u_sepc_host.close();
    check("busy", 17'(r.busy), 17'(program_busy));
    if (r.busy) begin
      u_sepc_host.await_ready(first, w);
      check("status", 17'h0, 17'(first));
      check("ready", 17'h1, 17'(w > PROG - 100 && w < PROG + 100));
    end
  endtask : run
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    resetn = 1'b0;
    power_good = 1'b0;  // supply not yet good
    word_width_select = 1'b1;
    rows[0] = {3'h5, 8'h05, 16'h1234, 5'h1B, 2'h0, 16'h0};
    rows[1] = {16'h0, 3'h4, 8'hC0, 5'h0B, 2'h0, 16'h0};
    rows[2] = {3'h5, 8'h05, 16'h1234, 5'h1B, 2'h1, 16'h0};
    rows[3] = {16'h0, 3'h6, 8'h05, 5'h0B, 2'h2, 16'h1234};
    rows[4] = {1'h0, 3'h5, 8'h05, 15'h1357, 5'h1A, 2'h0, 16'h0};
    rows[5] = {16'h0, 3'h6, 8'h05, 5'h0B, 2'h2, 16'h1234};
    rows[6] = {16'h0, 3'h7, 8'h05, 5'h0B, 2'h1, 16'h0};
    rows[7] = {16'h0, 3'h6, 8'h05, 5'h0B, 2'h2, 16'hFFFF};
    rows[8] = {3'h4, 8'h40, 16'hA5C3, 5'h1B, 2'h1, 16'h0};
    rows[9] = {16'h0, 3'h6, 8'h7F, 5'h0B, 2'h2, 16'hA5C3};
    rows[10] = {16'h0, 3'h4, 8'h80, 5'h0B, 2'h1, 16'h0};
    rows[11] = {16'h0, 3'h6, 8'h40, 5'h0B, 2'h2, 16'hFFFF};
    rows[12] = {16'h0, 3'h4, 8'h00, 5'h0B, 2'h0, 16'h0};
    rows[13] = {3'h5, 8'h03, 16'h0000, 5'h1B, 2'h0, 16'h0};
    rows[14] = {16'h0, 3'h6, 8'h03, 5'h0B, 2'h2, 16'hFFFF};
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check("idle", 17'h0, {15'h0, program_busy, serial_data_out_en});
    run(rows[1]);
    power_good <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) run(rows[i]);
    // byte organization
    word_width_select <= 1'b0;
    repeat (4) @(posedge clk);
    run({15'h0, 3'h4, 9'h180, 5'h0C, 2'h0, 16'h0});
    run({7'h0, 3'h5, 9'h0FE, 8'h3C, 5'h14, 2'h1, 16'h0});
    // a reselect after ready has been shown must not drive status again
    u_sepc_host.await_ready(sel_first, sel_wait);
    check("reselect", 17'h007D0, {sel_first === 1'b1, 16'(sel_wait)});
    run({15'h0, 3'h6, 9'h0FE, 5'h0C, 2'h2, 16'h3C});
    // supply loss in mid-cycle also relocks
    u_sepc_host.send({7'h0, 3'h5, 9'h011, 8'h55}, 20);
    u_sepc_host.close();
    repeat (10) @(posedge clk);
    check("busy", 17'h1, 17'(program_busy));
    power_good <= 1'b0;
    repeat (8) @(posedge clk);
    check("power", 17'h0, {15'h0, program_busy, serial_data_out_en});
    power_good <= 1'b1;
    repeat (4) @(posedge clk);
    run({7'h0, 3'h5, 9'h011, 8'h55, 5'h14, 2'h0, 16'h0});
    give_verdict();
  end
endmodule : sepc_top_tb
`default_nettype wire

// *** src/sepc_pkg.sv ***
// shared constants and types of the serial eeprom program control block
package sepc_pkg;
  // clock and link timing
  localparam int CLK_PERIOD_NS  = 50;                                      // core clock period
  localparam int DESEL_MIN_NS   = 200;                                     // deselect_min_time
  localparam int DESEL_MIN_CYC  = (DESEL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_TIME_NS   = 5000000;                                 // self-timed cycle, 5 ms
  localparam int PROG_CYC       = PROG_TIME_NS / CLK_PERIOD_NS;            // longest time, rounded down
  // array geometry
  localparam int ARRAY_BYTES    = 256;
  localparam int SWEEP_CYC      = ARRAY_BYTES;                             // one byte touched per cycle
  // exact clock counts per instruction, start bit included
  localparam logic [4:0] CLKS_SHORT_X8  = 5'd12;
  localparam logic [4:0] CLKS_SHORT_X16 = 5'd11;
  localparam logic [4:0] CLKS_LONG_X8   = 5'd20;
  localparam logic [4:0] CLKS_LONG_X16  = 5'd27;
  // decode point: start + opcode + address field
  localparam logic [4:0] DECODE_X8      = 5'd12;
  localparam logic [4:0] DECODE_X16     = 5'd11;
  // opcodes
  localparam logic [1:0] OP_SPECIAL     = 2'h0;
  localparam logic [1:0] OP_WRITE       = 2'h1;
  localparam logic [1:0] OP_READ        = 2'h2;
  localparam logic [1:0] OP_ERASE       = 2'h3;
  // special-function sub codes (top two address-field bits)
  localparam logic [1:0] SUB_LOCK       = 2'h0;
  localparam logic [1:0] SUB_PROG_ALL   = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL  = 2'h2;
  localparam logic [1:0] SUB_UNLOCK     = 2'h3;
  localparam logic [7:0] ERASED_BYTE    = 8'hFF;
  // reset values
  localparam logic       RST_DOUT       = 1'b0;
  localparam logic       RST_WEN        = 1'b0;

  // link front-end states
  typedef enum logic [1:0] {SEPC_WAIT_START, SEPC_SHIFT, SEPC_READ} sepc_state_t;

  // kind of self-timed cycle
  typedef enum logic [1:0] {SEPC_PK_ONE, SEPC_PK_ALL} sepc_pkind_t;

  // a launched program or erase cycle
  typedef struct packed {
    sepc_pkind_t kind;     // single location or whole array
    logic [7:0]  addr;     // location (word address in 16-bit mode)
    logic [15:0] data;     // pattern, all ones for erase
    logic        wide;     // 16-bit organization at launch
  } sepc_prog_t;
endpackage : sepc_pkg

// *** src/sepc_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sepc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;   // metastable stage, read only by stage two
  logic [WIDTH-1:0] stage2;   // safe copy

  // plain shift; no logic may tap stage1
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;
endmodule : sepc_sync
`default_nettype wire

// *** src/sepc_top.sv ***
// instruction decode and self-timed programming of a three-wire serial eeprom
// Summary of operation
// RULE_01 - program_all writes one word everywhere
// RULE_02 - select fall starts cycle; status after 200ns
// RULE_03 - erase starts on select falling edge
// RULE_04 - serial out 0 busy, 1 ready
// RULE_05 - erase_all sets every bit to one
// RULE_06 - ignore instructions until power good
// RULE_07 - power loss returns logic to reset
// RULE_08 - standby only when no cycle runs
// RULE_09 - start, opcode, address field layout decoded
// RULE_10 - program_all_cmd is special 01 plus data
// RULE_11 - erase_all is special 10, no data
// RULE_12 - exact clock counts per instruction
// RULE_13 - host waits for ready before instructing
// RULE_14 - width select high means 16-bit words
// RULE_15 - program needs unlock; program_lock relocks
// RULE_16 - read sends zero then data, rising edges
// RULE_17 - sample on rising clock, start bit one
// RULE_18 - cycle length is a parameter
`timescale 1ns/1ps
`default_nettype none
module sepc_top
  import sepc_pkg::*;
#(
  parameter int PROG_CYCLES = sepc_pkg::PROG_CYC  // shorten in simulation, keep >= sepc_pkg::SWEEP_CYC
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic power_good,         // supply above threshold
  input  wire logic chip_select,
  input  wire logic serial_clock,
  input  wire logic serial_data_in,
  input  wire logic word_width_select,  // high: 16-bit words
  output logic      serial_data_out,
  output logic      serial_data_out_en, // high while driving the pin
  output logic      program_busy        // self-timed cycle running
);
  import sepc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge finding
  logic [4:0] pins_s;        // synchronised pins
  logic       pgood, cs, sk, din, wide;
  logic       sk_d, cs_d;    // one cycle later, for edges

  sepc_sync #(.WIDTH(5)) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({power_good, chip_select, serial_clock, serial_data_in, word_width_select}),
    .sync_out (pins_s)
  );
  assign {pgood, cs, sk, din, wide} = pins_s;

  logic sk_rise, cs_fall;
  assign sk_rise = sk & ~sk_d;   // RULE_17
  assign cs_fall = cs_d & ~cs;

  //////////////////////////////////////////////////////////////////////////////
  // state
  sepc_state_t state, next_state;
  logic [4:0]  cnt, next_cnt;          // clocks since start bit, saturating
  logic [25:0] sr, next_sr;            // bits after the start bit
  logic [1:0]  op, next_op;            // decoded opcode
  logic [8:0]  af, next_af;            // decoded address field
  logic        wen, next_wen;          // programming unlocked
  logic [15:0] rd_sr, next_rd_sr;      // read shifter, msb first
  logic [4:0]  rd_left, next_rd_left;  // bits still to send of current word
  logic [7:0]  rd_addr, next_rd_addr;  // next location to stream
  logic        busy, next_busy;
  logic [31:0] timer, next_timer;      // self-timed cycle counter
  sepc_prog_t  prog, next_prog;
  logic [2:0]  low_cnt, next_low_cnt;  // select-low time after launch
  logic        stat_arm, next_stat_arm;
  logic        dout, next_dout;
  logic        oe, next_oe;

  // array storage; 16-bit word n is bytes 2n (high) and 2n+1 (low)
  logic [7:0]  mem [ARRAY_BYTES];

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  logic [25:0] sh;           // shifter with the new bit
  logic [4:0]  cnt_inc;
  logic [8:0]  af_new;
  logic [1:0]  op_new;
  logic [7:0]  loc;          // address of the decoded instruction
  logic [1:0]  sub;          // special sub code
  logic        cnt_ok;       // exact clock count met
  logic        is_long;

  // read word fetch, left aligned
  function automatic logic [15:0] fetch(input logic [7:0] a, input logic w);
    logic [15:0] r;
    r = w ? {mem[{a[6:0], 1'b0}], mem[{a[6:0], 1'b1}]} : {mem[a], 8'h00};
    return r;
  endfunction : fetch

  always_comb begin
    sh      = {sr[24:0], din};
    cnt_inc = (cnt == 5'h1F) ? cnt : cnt + 5'h01;
    af_new  = wide ? {1'b0, sh[7:0]} : sh[8:0];      // RULE_14
    op_new  = wide ? sh[9:8] : sh[10:9];             // RULE_09
    loc     = wide ? {1'b0, af[6:0]} : af[7:0];
    sub     = wide ? af[7:6] : af[8:7];              // RULE_10 RULE_11
    is_long = (op == OP_WRITE) || (op == OP_SPECIAL && sub == SUB_PROG_ALL);
    cnt_ok  = wide ? (cnt == (is_long ? CLKS_LONG_X16 : CLKS_SHORT_X16))
                   : (cnt == (is_long ? CLKS_LONG_X8  : CLKS_SHORT_X8));  // RULE_12
  end

  //////////////////////////////////////////////////////////////////////////////
  // link front end: shift, decode, read stream, launch
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_sr       = sr;
    next_op       = op;
    next_af       = af;
    next_wen      = wen;
    next_rd_sr    = rd_sr;
    next_rd_left  = rd_left;
    next_rd_addr  = rd_addr;
    next_prog     = prog;
    next_busy     = busy;
    next_timer    = timer;
    next_low_cnt  = low_cnt;
    next_stat_arm = stat_arm;
    if (!cs) begin
      // deselected: back to waiting for a start bit
      next_state = SEPC_WAIT_START;
      // status is offered once; a reselect after the cycle has ended shows nothing
      if (!busy)
        next_stat_arm = 1'b0;                                            // RULE_04
      if (low_cnt != DESEL_MIN_CYC[2:0])
        next_low_cnt = low_cnt + 3'h1;
    end
    if (cs_fall && state == SEPC_SHIFT && cnt_ok && !busy) begin
      // instruction framed by select: act on it now
      next_low_cnt = 3'h0;
      unique case (op)
        OP_SPECIAL: begin
          if (sub == SUB_UNLOCK)
            next_wen = 1'b1;                                             // RULE_15
          else if (sub == SUB_LOCK)
            next_wen = 1'b0;                                             // RULE_15
          else if (wen) begin
            next_busy     = 1'b1;                                        // RULE_02
            next_stat_arm = 1'b1;
            next_prog     = '{kind: SEPC_PK_ALL, addr: 8'h00, wide: wide,
                              data: (sub == SUB_ERASE_ALL) ? {ERASED_BYTE, ERASED_BYTE}  // RULE_05
                                  : (wide ? sr[15:0] : {8'h00, sr[7:0]})};           // RULE_01
          end
        end
        OP_WRITE, OP_ERASE: begin
          if (wen) begin
            next_busy     = 1'b1;                                        // RULE_03
            next_stat_arm = 1'b1;
            next_prog     = '{kind: SEPC_PK_ONE, addr: loc, wide: wide,
                              data: (op == OP_ERASE) ? {ERASED_BYTE, ERASED_BYTE}
                                  : (wide ? sr[15:0] : {8'h00, sr[7:0]})};
          end
        end
        OP_READ: ;
      endcase
    end else if (cs && sk_rise) begin
      unique case (state)
        SEPC_WAIT_START: begin
          // a start bit is ignored while a cycle runs
          if (din && !busy) begin                                        // RULE_17 RULE_08
            next_state    = SEPC_SHIFT;
            next_cnt      = 5'h01;
            next_sr       = '0;
            next_stat_arm = 1'b0;
          end
        end
        SEPC_SHIFT: begin
          next_sr  = sh;
          next_cnt = cnt_inc;
          if (cnt_inc == (wide ? DECODE_X16 : DECODE_X8)) begin
            next_op = op_new;
            next_af = af_new;
            if (op_new == OP_READ) begin
              next_state   = SEPC_READ;                                  // RULE_16
              next_rd_sr   = fetch(wide ? {1'b0, af_new[6:0]} : af_new[7:0], wide);
              next_rd_left = wide ? 5'd16 : 5'd8;
              next_rd_addr = (wide ? {1'b0, af_new[6:0]} : af_new[7:0]) + 8'h01;
            end
          end
        end
        SEPC_READ: begin
          if (rd_left != 5'h00) begin
            next_rd_sr   = {rd_sr[14:0], 1'b0};
            next_rd_left = rd_left - 5'h01;
          end else begin
            // stream on into the next location, wrapping
            next_rd_sr   = {fetch(rd_addr, wide)} << 1;
            next_rd_left = wide ? 5'd15 : 5'd7;
            next_rd_addr = wide ? {1'b0, rd_addr[6:0] + 7'h01} : rd_addr + 8'h01;
          end
        end
        default: next_state = SEPC_WAIT_START;
      endcase
    end
    // self-timed cycle
    if (busy) begin
      if (timer >= PROG_CYCLES - 1) begin                               // RULE_18
        next_busy  = 1'b0;
        next_timer = '0;
        if (!cs)
          next_stat_arm = 1'b0;  // finished unseen: no status on reselect
      end else
        next_timer = timer + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial out: read data, or status after the deselect time
  logic show_status;
  assign show_status = cs && stat_arm && (state == SEPC_WAIT_START)
                       && (low_cnt == DESEL_MIN_CYC[2:0]);              // RULE_02

  always_comb begin
    next_dout = dout;
    next_oe   = 1'b0;
    if (show_status) begin
      next_dout = ~busy;                                                 // RULE_04
      next_oe   = 1'b1;
    end else if (state == SEPC_READ && cs) begin
      next_oe = 1'b1;
      if (sk_rise)
        next_dout = (rd_left != 5'h00) ? rd_sr[15] : fetch(rd_addr, wide) >> 15 != 16'h0;  // RULE_16
    end else if (state == SEPC_SHIFT && cs && sk_rise && next_state == SEPC_READ) begin
      next_dout = 1'b0;                                                  // RULE_16
      next_oe   = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers; power loss holds everything but the sk_d and cs_d edge flops in reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= SEPC_WAIT_START; cnt <= '0; sr <= '0; op <= OP_SPECIAL; af <= '0;
      wen <= RST_WEN; rd_sr <= '0; rd_left <= '0; rd_addr <= '0; busy <= 1'b0;
      timer <= '0; prog <= '0; low_cnt <= '0; stat_arm <= 1'b0;
      dout <= RST_DOUT; oe <= 1'b0; sk_d <= 1'b0; cs_d <= 1'b0;
    end else if (!pgood) begin                                           // RULE_06 RULE_07
      state <= SEPC_WAIT_START; cnt <= '0; sr <= '0; op <= OP_SPECIAL; af <= '0;
      wen <= RST_WEN; rd_sr <= '0; rd_left <= '0; rd_addr <= '0; busy <= 1'b0;
      timer <= '0; prog <= '0; low_cnt <= '0; stat_arm <= 1'b0;
      dout <= RST_DOUT; oe <= 1'b0; sk_d <= sk; cs_d <= cs;
    end else begin
      state <= next_state; cnt <= next_cnt; sr <= next_sr; op <= next_op; af <= next_af;
      wen <= next_wen; rd_sr <= next_rd_sr; rd_left <= next_rd_left; rd_addr <= next_rd_addr;
      busy <= next_busy; timer <= next_timer; prog <= next_prog; low_cnt <= next_low_cnt;
      stat_arm <= next_stat_arm; dout <= next_dout; oe <= next_oe; sk_d <= sk; cs_d <= cs;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // array sweep: one byte per cycle over the first cycles of the timer,
  // so whole-array operations need no wide write port
  logic [7:0] idx;
  logic       hit;
  logic [7:0] wbyte;
  assign idx   = timer[7:0];
  assign hit   = (prog.kind == SEPC_PK_ALL)
                 || (prog.wide ? (idx[7:1] == prog.addr[6:0]) : (idx == prog.addr));
  assign wbyte = (prog.wide && !idx[0]) ? prog.data[15:8] : prog.data[7:0];

  always_ff @(posedge clk) begin
    if (busy && pgood && timer < SWEEP_CYC && hit)
      mem[idx] <= wbyte;                                                 // RULE_01 RULE_05
  end

  assign serial_data_out    = dout;
  assign serial_data_out_en = oe;
  assign program_busy       = busy;
endmodule : sepc_top
`default_nettype wire
